// [mcu_wd_consts.svh]
// Purpose: Offsets, field positions, reset values and counts of the
//          runaway watchdog.
// Assumes: Wishbone byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef MCU_WD_CONSTS_SVH
`define MCU_WD_CONSTS_SVH

`define WD_ADR_W          8
`define WD_ADR_CTRL       8'h00
`define WD_ADR_FET        8'h04
`define WD_ADR_STAT       8'h08
`define WD_ADR_CLR        8'h0c
`define WD_ADR_IEN        8'h10
`define WD_ADR_CNT        8'h14

`define WD_CTRL_TSEL_LO   0
`define WD_CTRL_TSEL_HI   1
`define WD_CTRL_ACTSEL    2
`define WD_CTRL_REFRESH   3

`define WD_FET_CHG        0
`define WD_FET_DIS        1

`define WD_ST_FLAG        0
`define WD_ST_TRIP        1
`define WD_ST_RST         2
`define WD_ST_W           3

`define WD_TSEL_RST       2'b00
`define WD_ACTSEL_RST     1'b0
`define WD_FET_RST        1'b0
`define WD_IEN_RST        3'b000

`define WD_TSEL_2S        2'b00
`define WD_TSEL_4S        2'b01
`define WD_TSEL_8S        2'b10

`define WD_OSC_DIV        4
`define WD_DIV_W          2
`define WD_PRE_BITS       3
`define WD_CNT_BITS       16
`define WD_PRE_TOP_2S     1
`define WD_PRE_TOP_4S     3
`define WD_PRE_TOP_8S     7

`define WD_RST_LOW_CYCLES 16

`endif

// [mcu_wd_pkg.sv]
// Purpose: Types shared by the runaway watchdog.
// Assumes: Nothing beyond the constants header.
// Notes:   Stage of the overflow sequence.
package mcu_wd_pkg;
	typedef enum logic [1:0] {
		STAGE_RUN,
		STAGE_FLAGGED,
		STAGE_TRIPPED
	} stage_t;
endpackage

// [pin_sync.sv]
// Purpose: Bring a pin into the clk domain and report its rising edge.
// Assumes: Pin is asynchronous to clk.
// Notes:   Level moves only when the second and third stages agree.
module pin_sync (
	input  logic clk,
	input  logic rst_n,
	input  logic pin,
	output logic level,
	output logic rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;
	logic rise_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// First stage feeds only the second; filter uses stages two and three
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= 1'b0;
			rise_r  <= 1'b0;
		end else begin
			if (s2_r == s3_r)
				level_r <= s3_r;
			rise_r <= (s2_r == s3_r) && s3_r && !level_r;
		end
	end

	assign level = level_r;
	assign rise  = rise_r;
endmodule

// [runaway_counter.sv]
// Purpose: Prescaler plus counter that times out the runaway period.
// Assumes: tick is a one-cycle pulse at the divided oscillator rate.
// Notes:   Longest period uses every bit of the chain.
`include "mcu_wd_consts.svh"

module runaway_counter #(
	parameter int PRE_W = `WD_PRE_BITS,
	parameter int CNT_W = `WD_CNT_BITS
) (
	input  logic                   clk,
	input  logic                   rst_n,
	input  logic                   tick,
	input  logic                   restart,
	input  logic [1:0]             timeSel,
	output logic                   ovf,
	output logic [PRE_W+CNT_W-1:0] count
);
	logic [PRE_W-1:0] pre_r;
	logic [CNT_W-1:0] cnt_r;
	logic             ovf_r;
	logic             preWrap;

	function automatic logic [PRE_W-1:0] preTop(input logic [1:0] s);
		case (s)
			`WD_TSEL_2S: preTop = PRE_W'(`WD_PRE_TOP_2S);
			`WD_TSEL_4S: preTop = PRE_W'(`WD_PRE_TOP_4S);
			default:     preTop = PRE_W'(`WD_PRE_TOP_8S);
		endcase
	endfunction

	assign preWrap = tick && (pre_r == preTop(timeSel));

	// Prescaler feeding the wide counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pre_r <= '0;
		else if (restart || preWrap)
			pre_r <= '0;
		else if (tick)
			pre_r <= pre_r + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= '0;
		else if (restart)
			cnt_r <= '0;
		else if (preWrap)
			cnt_r <= cnt_r + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ovf_r <= 1'b0;
		else
			ovf_r <= !restart && preWrap && (&cnt_r);
	end

	assign ovf   = ovf_r;
	assign count = {cnt_r, pre_r};
endmodule

// [mcu_runaway_watchdog.sv]
// Purpose: Runaway watchdog for the companion controller, with FET
//          cut-off and reset request, reached over classic Wishbone.
// Assumes: oscIn and runawayRefreshIn are pins outside the clk domain.
// Notes:   oscIn must be well below half the clk rate.
`include "mcu_wd_consts.svh"

module mcu_runaway_watchdog #(
	parameter int RST_LOW_CYCLES = `WD_RST_LOW_CYCLES,
	// A narrower counter shortens every period by the same factor
	parameter int CNT_W          = `WD_CNT_BITS
) (
	input  logic        clk,
	input  logic        rst_n,
	input  logic        cyc_i,
	input  logic        stb_i,
	input  logic        we_i,
	input  logic [7:0]  adr_i,
	input  logic [3:0]  sel_i,
	input  logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic        ack_o,
	input  logic        oscIn,
	input  logic        runawayRefreshIn,
	output logic        chargeFetEnable,
	output logic        dischargeFetEnable,
	output logic        frontendResetOut_n,
	output logic        irq
);
	import mcu_wd_pkg::*;

	localparam int CHAIN_W = `WD_PRE_BITS + CNT_W;
	localparam int RC_W    = $clog2(RST_LOW_CYCLES + 1);

	logic                 ack_r;
	logic [31:0]          dat_r;
	logic                 busHit;
	logic                 wrEn;

	logic                 oscRise;
	logic                 refreshRise;
	logic [`WD_DIV_W-1:0] div_r;
	logic                 divTick;

	logic [1:0]           timeSel_r;
	logic                 actionSel_r;
	logic                 swRefresh_r;
	logic                 selChange_r;
	logic                 restart;

	logic                 chargeFet_r;
	logic                 dischargeFet_r;
	logic [`WD_ST_W-1:0]  status_r;
	logic [`WD_ST_W-1:0]  ien_r;
	logic [`WD_ST_W-1:0]  stEvent;
	logic                 irq_r;

	stage_t               stage_r;
	logic                 ovf;
	logic                 firstOvf;
	logic                 secondOvf;
	logic                 resetReq;
	logic [CHAIN_W-1:0]   chainCount;

	logic [RC_W-1:0]      rstCnt_r;
	logic                 rstOut_n_r;

	// Low-byte write strobe for one register address
	function automatic logic wrLow(input logic [7:0] off);
		wrLow = wrEn && sel_i[0] && (adr_i == off);
	endfunction

	// Time-select field of a control word
	function automatic logic [1:0] tselField(input logic [31:0] w);
		tselField = {w[`WD_CTRL_TSEL_HI], w[`WD_CTRL_TSEL_LO]};
	endfunction

	// Pin capture; the pin itself carries the pull-down, so an idle
	// line settles low and gives no rising edge
	pin_sync oscSync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (oscIn),
		.level (),
		.rise  (oscRise)
	);

	pin_sync refreshSync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (runawayRefreshIn),
		.level (),
		.rise  (refreshRise)
	);

	// Divide the oscillator by four
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			div_r <= '0;
		else if (oscRise)
			div_r <= div_r + 1'b1;
	end

	assign divTick = oscRise && (div_r == `WD_DIV_W'(`WD_OSC_DIV - 1));

	// Any refresh source restarts the chain
	assign restart = refreshRise || swRefresh_r || selChange_r;

	// Private oscillator path and counter
	runaway_counter #(
		.PRE_W (`WD_PRE_BITS),
		.CNT_W (CNT_W)
	) chain (
		.clk     (clk),
		.rst_n   (rst_n),
		.tick    (divTick),
		.restart (restart),
		.timeSel (timeSel_r),
		.ovf     (ovf),
		.count   (chainCount)
	);

	assign firstOvf  = ovf && (stage_r == STAGE_RUN);
	assign secondOvf = ovf && (stage_r != STAGE_RUN);
	assign resetReq  = secondOvf && actionSel_r;

	// Overflow sequence; a refresh ends the run of overflows, so
	// the next overflow after any refresh counts as a first one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			stage_r <= STAGE_RUN;
		else if (restart)
			stage_r <= STAGE_RUN;
		else if (firstOvf)
			stage_r <= STAGE_FLAGGED;
		else if (secondOvf)
			stage_r <= STAGE_TRIPPED;
	end

	// Wishbone classic slave: one wait state, ack for one cycle
	assign busHit = cyc_i && stb_i && !ack_r;
	assign wrEn   = busHit && we_i;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= busHit;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_r <= '0;
		end else if (busHit && !we_i) begin
			if (adr_i == `WD_ADR_CTRL)
				dat_r <= {29'h0, actionSel_r, timeSel_r};
			else if (adr_i == `WD_ADR_FET)
				dat_r <= {30'h0, dischargeFet_r, chargeFet_r};
			else if (adr_i == `WD_ADR_STAT)
				dat_r <= {29'h0, status_r};
			else if (adr_i == `WD_ADR_IEN)
				dat_r <= {29'h0, ien_r};
			else if (adr_i == `WD_ADR_CNT)
				dat_r <= 32'(chainCount); // Snapshot, chain keeps running
			else
				dat_r <= '0; // Clear register and holes read zero
		end
	end

	// Control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timeSel_r   <= `WD_TSEL_RST;
			actionSel_r <= `WD_ACTSEL_RST;
		end else if (wrLow(`WD_ADR_CTRL)) begin
			timeSel_r   <= tselField(dat_i);
			actionSel_r <= dat_i[`WD_CTRL_ACTSEL];
		end
	end

	// Restart only when the setting really changes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			selChange_r <= 1'b0;
		else
			selChange_r <= wrLow(`WD_ADR_CTRL) &&
				(tselField(dat_i) != timeSel_r);
	end

	// Software refresh strobe, self clearing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			swRefresh_r <= 1'b0;
		else
			swRefresh_r <= wrLow(`WD_ADR_CTRL) &&
				dat_i[`WD_CTRL_REFRESH];
	end

	// FET enables; the trip wins over a software write so that a
	// stuck controller cannot re-enable the FETs in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chargeFet_r    <= `WD_FET_RST;
			dischargeFet_r <= `WD_FET_RST;
		end else if (secondOvf) begin
			chargeFet_r    <= 1'b0;
			dischargeFet_r <= 1'b0;
		end else if (wrLow(`WD_ADR_FET)) begin
			chargeFet_r    <= dat_i[`WD_FET_CHG];
			dischargeFet_r <= dat_i[`WD_FET_DIS];
		end
	end

	// Sticky status; a new event beats a clear in the same cycle
	assign stEvent = {resetReq, secondOvf, firstOvf};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			status_r <= '0;
		else if (wrLow(`WD_ADR_CLR))
			status_r <= (status_r & ~dat_i[`WD_ST_W-1:0]) | stEvent;
		else
			status_r <= status_r | stEvent;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ien_r <= `WD_IEN_RST;
		else if (wrLow(`WD_ADR_IEN))
			ien_r <= dat_i[`WD_ST_W-1:0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_r <= 1'b0;
		else
			irq_r <= |(status_r & ien_r);
	end

	// Reset pulse toward the controller; held a fixed time so the
	// controller sees a clean low even if it is wedged
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rstCnt_r <= '0;
		else if (resetReq)
			rstCnt_r <= RC_W'(RST_LOW_CYCLES);
		else if (rstCnt_r != '0)
			rstCnt_r <= rstCnt_r - 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rstOut_n_r <= 1'b1;
		else
			rstOut_n_r <= !(resetReq || (rstCnt_r > RC_W'(1)));
	end

	assign dat_o              = dat_r;
	assign ack_o              = ack_r;
	assign chargeFetEnable    = chargeFet_r;
	assign dischargeFetEnable = dischargeFet_r;
	assign frontendResetOut_n = rstOut_n_r;
	assign irq                = irq_r;
endmodule

// [mcu_wd_asserts.sv]
// Purpose: Port-level checks of the runaway watchdog.
// Assumes: One clock domain, classic Wishbone slave.
// Notes:   Trip checks only wake on a real overflow.
`include "mcu_wd_consts.svh"
module mcu_wd_asserts #(
	parameter int RST_LOW_CYCLES = `WD_RST_LOW_CYCLES
) (
	input logic        clk,
	input logic        rst_n,
	input logic        cyc_i,
	input logic        stb_i,
	input logic        we_i,
	input logic [7:0]  adr_i,
	input logic [3:0]  sel_i,
	input logic [31:0] dat_i,
	input logic [31:0] dat_o,
	input logic        ack_o,
	input logic        chargeFetEnable,
	input logic        dischargeFetEnable,
	input logic        frontendResetOut_n
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int RST_HI_MAX = RST_LOW_CYCLES + 2;
	wire req = cyc_i && stb_i;
	wire fetWr = req && we_i && adr_i == `WD_ADR_FET && sel_i[0];
	wire rdOff = req && !we_i && adr_i > `WD_ADR_CNT;
	wire rdCnt = req && !we_i && adr_i == `WD_ADR_CNT;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	ack_after_req_a: assert property (req && !ack_o |=> ack_o)
		else $error("ack missing");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	ack_cause_a: assert property (ack_o |-> $past(req))
		else $error("ack without request");
	chg_on_write_a: assert property ($rose(chargeFetEnable)
		|-> $past(fetWr && dat_i[`WD_FET_CHG])) else $error("charge on");
	dis_on_write_a: assert property ($rose(dischargeFetEnable)
		|-> $past(fetWr && dat_i[`WD_FET_DIS])) else $error("dis on");
	trip_both_off_a: assert property ($fell(chargeFetEnable)
		&& !$past(fetWr) |-> !dischargeFetEnable) else $error("one FET");
	rst_fets_off_a: assert property ($fell(frontendResetOut_n)
		|-> !chargeFetEnable && !dischargeFetEnable) else $error("FETs on");
	rst_out_len_a: assert property ($fell(frontendResetOut_n)
		|-> ##[RST_LOW_CYCLES:RST_HI_MAX] frontendResetOut_n)
		else $error("reset length");
	unmapped_zero_a: assert property (ack_o && $past(rdOff)
		|-> dat_o == 32'h0) else $error("unmapped data");
	count_width_a: assert property (ack_o && $past(rdCnt)
		|-> dat_o[31:19] == 13'h0) else $error("count too wide");
endmodule

bind mcu_runaway_watchdog mcu_wd_asserts #(
	.RST_LOW_CYCLES(RST_LOW_CYCLES)
) chk (
	.clk(clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o), .chargeFetEnable(chargeFetEnable),
	.dischargeFetEnable(dischargeFetEnable),
	.frontendResetOut_n(frontendResetOut_n)
);

// [mcu_refresh_model.sv]
// Purpose: Controller side of the refresh line.
// Assumes: Pulse request is one cycle wide.
// Notes:   Idle line rests low, as the pull-down leaves it.
module mcu_refresh_model (
	input  logic clk,
	input  logic rst_n,
	input  logic pulseReq,
	output logic refreshOut
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] holdCnt_r;
	// Four cycles high, longer than the pin filter needs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			holdCnt_r <= 3'h0;
		end else if (pulseReq) begin
			holdCnt_r <= 3'h4;
		end else if (holdCnt_r != 3'h0) begin
			holdCnt_r <= holdCnt_r - 3'h1;
		end
	end
	assign refreshOut = holdCnt_r != 3'h0;
endmodule

// [tb_mcu_runaway_watchdog.sv]
// Purpose: Register, count and refresh tests of the runaway watchdog.
// Assumes: Oscillator pin made here, rising every 8 clk cycles.
// Notes:   A narrow-counter copy reaches the trips within the run.
`include "mcu_wd_consts.svh"
module tb_mcu_runaway_watchdog;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, req, we, oscIn, refReq, refLine;
	logic        chg, dis, rstOut_n, irq, ack;
	logic        chg2, dis2, rst2_n, irq2;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, dout, rdat;
	logic [2:0]  oscDiv;
	int          errorCnt, nTests, cycles, waitN;
	int          expCnt [4] = '{50, 25, 12, 12};

	mcu_runaway_watchdog DUT (
		.clk(clk), .rst_n(rst_n), .cyc_i(req), .stb_i(req), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dout), .ack_o(ack),
		.oscIn(oscIn), .runawayRefreshIn(refLine), .chargeFetEnable(chg),
		.dischargeFetEnable(dis), .frontendResetOut_n(rstOut_n), .irq(irq)
	);
	mcu_refresh_model PART (
		.clk(clk), .rst_n(rst_n), .pulseReq(refReq), .refreshOut(refLine)
	);
	// Same bus and pins, 2-bit counter: overflows every 256 cycles at the 2s setting, 1024 at 8s
	mcu_runaway_watchdog #(.CNT_W(2)) shortDut (
		.clk(clk), .rst_n(rst_n), .cyc_i(req), .stb_i(req), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(), .ack_o(),
		.oscIn(oscIn), .runawayRefreshIn(refLine), .chargeFetEnable(chg2),
		.dischargeFetEnable(dis2), .frontendResetOut_n(rst2_n), .irq(irq2)
	);

	initial begin
		{clk, rst_n, req, we, oscIn, refReq} = 6'h0;
		{adr, sel, wdat, oscDiv, errorCnt, nTests, cycles} = '0;
	end
	always #20 clk = ~clk;
	always @(posedge clk) begin
		oscDiv <= oscDiv + 3'h1;
		oscIn <= oscDiv[2];
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errorCnt++;
			$display("[FAIL] %0t timeout", $time);
			endOfTest();
		end
	end

	task automatic check(input logic ok, input string msg);
		nTests++;
		if (ok !== 1'b1) begin
			errorCnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic wbAccess(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		{req, we, adr, wdat, sel} <= {1'b1, w, a, d, s};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		check(ack === 1'b1, "no ack");
		rdat = dout;
		req <= 1'b0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		wbAccess(1'b0, a, 32'h0, 4'hf);
		check(rdat === e, "read data");
	endtask
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		check(!chg && !dis && rstOut_n && !irq, "reset pins");
		rdChk(`WD_ADR_CTRL, 32'h0);
		rdChk(`WD_ADR_STAT, 32'h0);
		rdChk(`WD_ADR_IEN, 32'h0);
		rdChk(8'h18, 32'h0);
		wbAccess(1'b1, `WD_ADR_FET, 32'h3, 4'hf);
		check(chg === 1'b1 && dis === 1'b1, "FETs on");
		wbAccess(1'b1, `WD_ADR_FET, 32'h0, 4'he);
		rdChk(`WD_ADR_FET, 32'h3);
		wbAccess(1'b1, `WD_ADR_IEN, 32'h7, 4'hf);
		rdChk(`WD_ADR_IEN, 32'h7);
		wbAccess(1'b1, `WD_ADR_CLR, 32'h7, 4'hf);
		rdChk(`WD_ADR_STAT, 32'h0);
		check(irq === 1'b0, "irq idle");
		wbAccess(1'b1, `WD_ADR_CTRL, 32'h4, 4'hf);
		rdChk(`WD_ADR_CTRL, 32'h4);
		$display("registers done");
		// Each code differs from the last, so each write restarts
		for (int i = 0; i < 4; i++) begin
			wbAccess(1'b1, `WD_ADR_CTRL, (i + 1) % 4, 4'hf);
			repeat (3200) @(posedge clk);
			wbAccess(1'b0, `WD_ADR_CNT, 32'h0, 4'hf);
			check(rdat[18:3] >= expCnt[(i + 1) % 4] - 2
				&& rdat[18:3] <= expCnt[(i + 1) % 4] + 2, "rate");
		end
		check(rstOut_n === 1'b1 && chg === 1'b1, "idle line");
		$display("count done");
		@(posedge clk);
		refReq <= 1'b1;
		@(posedge clk);
		refReq <= 1'b0;
		repeat (20) @(posedge clk);
		wbAccess(1'b0, `WD_ADR_CNT, 32'h0, 4'hf);
		check(rdat[18:3] === 16'h0, "pin refresh");
		repeat (640) @(posedge clk);
		wbAccess(1'b1, `WD_ADR_CTRL, 32'h0, 4'hf);
		wbAccess(1'b0, `WD_ADR_CNT, 32'h0, 4'hf);
		check(rdat[18:3] >= 16'h8, "same code kept");
		wbAccess(1'b1, `WD_ADR_CTRL, 32'h8, 4'hf);
		wbAccess(1'b0, `WD_ADR_CNT, 32'h0, 4'hf);
		check(rdat[18:3] === 16'h0, "soft refresh");
		$display("refresh done");
		wbAccess(1'b1, `WD_ADR_CTRL, 32'hc, 4'hf);
		wbAccess(1'b1, `WD_ADR_FET, 32'h3, 4'hf);
		wbAccess(1'b1, `WD_ADR_CLR, 32'h7, 4'hf);
		repeat (2) @(posedge clk);
		check(irq2 === 1'b0, "irq cleared");
		waitN = 0;
		while (irq2 !== 1'b1 && waitN < 400) begin
			@(posedge clk);
			waitN++;
		end
		check(irq2 === 1'b1 && chg2 === 1'b1 && dis2 === 1'b1
			&& rst2_n === 1'b1, "first overflow");
		waitN = 0;
		while (chg2 !== 1'b0 && waitN < 400) begin
			@(posedge clk);
			waitN++;
		end
		check(chg2 === 1'b0 && dis2 === 1'b0
			&& rst2_n === 1'b0, "trip with reset");
		repeat (13) @(posedge clk);
		check(rst2_n === 1'b0, "reset held");
		repeat (3) @(posedge clk);
		check(rst2_n === 1'b1, "reset ends");
		wbAccess(1'b1, `WD_ADR_CTRL, 32'h8, 4'hf);
		wbAccess(1'b1, `WD_ADR_FET, 32'h3, 4'hf);
		waitN = 0;
		while (chg2 !== 1'b0 && waitN < 700) begin
			@(posedge clk);
			waitN++;
		end
		check(chg2 === 1'b0 && dis2 === 1'b0
			&& rst2_n === 1'b1, "trip only");
		check(chg === 1'b1 && rstOut_n === 1'b1, "long period");
		$display("trip done");
		endOfTest();
	end
endmodule
